/* File: hdl/gpmc_pkg.sv */
// Purpose: Shared constants and types for the gauge power-mode controller
// Assumes: 125 MHz core clock, 16-bit measurement words
// Notes:   Link pins are sampled, not used as clocks
package gpmc_pkg;
    localparam int CLK_MHZ          = 125;
    localparam int DATA_W           = 16;
    localparam int I2C_ADDR_W       = 7;
    // Time figures and derived cycle counts
    localparam int CAL_TIME_US      = 10;
    localparam int CAL_CYCLES       = CAL_TIME_US * CLK_MHZ;
    localparam int OCV_TIME_US      = 10;
    localparam int OCV_CYCLES       = OCV_TIME_US * CLK_MHZ;
    localparam int CNT_W            = 24;
    localparam logic [CNT_W-1:0] DOZE_PERIOD_DEF = 24'h0f4240;
    localparam logic [I2C_ADDR_W-1:0] DEV_ADDR_DEF = 7'h55; // Arbitrary
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

    typedef enum logic [3:0]
    {
        GPMC_WAIT_ABSENT = 4'h0,
        GPMC_INIT_OCV    = 4'h1,
        GPMC_NORMAL      = 4'h2,
        GPMC_CAL         = 4'h3,
        GPMC_DOZE        = 4'h4,
        GPMC_FAST_DOZE   = 4'h5,
        GPMC_DEEP_OFF    = 4'h6,
        GPMC_CMD_WAKE    = 4'h7
    } gpmc_state_t;

    typedef struct packed
    {
        logic [DATA_W-1:0] low_capacity_set_level;
        logic [DATA_W-1:0] low_capacity_clear_level;
        logic [DATA_W-1:0] end_discharge_voltage;
        logic [DATA_W-1:0] doze_current_level;
        logic [DATA_W-1:0] wake_current_threshold;
        logic [DATA_W-1:0] deep_off_current_level;
        logic [DATA_W-1:0] deep_off_voltage_level;
    } gpmc_cfg_t;

    typedef struct packed
    {
        logic [DATA_W-1:0] remaining_capacity_value;
        logic [DATA_W-1:0] average_current_value;
        logic [DATA_W-1:0] sense_current;
        logic [DATA_W-1:0] cell_voltage;
        logic [DATA_W-1:0] state_of_charge;
    } gpmc_meas_t;
endpackage

/* File: hdl/gpmc_i2c_addr_det.sv */
// Purpose: Watches the I2C pins and flags address matches that follow a start
// Assumes: Pins sampled at core clock; three-stage sync per pin
// Notes:   Listens only, never drives the bus
`timescale 1ns/1ns
`default_nettype none
module gpmc_i2c_addr_det
(
    input  wire logic                            ref_clk_in,
    input  wire logic                            rst_b_in,
    input  wire logic                            scl_in,
    input  wire logic                            sda_in,
    input  wire logic [gpmc_pkg::I2C_ADDR_W-1:0] dev_addr_in,
    output logic                                 addr_hit_out,
    output logic                                 activity_out
);
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       scl_q;
    logic       sda_q;
    logic       scl_prev;
    logic       sda_prev;
    logic       in_addr;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            // Change accepted only once stages two and three agree
            if (scl_s[1] == scl_s[2])
                scl_q <= scl_s[2];
            if (sda_s[1] == sda_s[2])
                sda_q <= sda_s[2];
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            scl_prev     <= 1'b1;
            sda_prev     <= 1'b1;
            in_addr      <= 1'b0;
            bit_cnt      <= 4'h0;
            shreg        <= 8'h00;
            addr_hit_out <= 1'b0;
            activity_out <= 1'b0;
        end
        else
        begin
            scl_prev     <= scl_q;
            sda_prev     <= sda_q;
            addr_hit_out <= 1'b0;
            activity_out <= 1'b0;
            if (scl_q && sda_prev && !sda_q)
            begin
                in_addr <= 1'b1;
                bit_cnt <= 4'h0;
            end
            else if (in_addr && scl_q && !scl_prev)
            begin
                shreg   <= {shreg[6:0], sda_q};
                bit_cnt <= bit_cnt + 4'h1;
                if (bit_cnt == 4'h7)
                begin
                    in_addr <= 1'b0;
                    // Foreign addresses never reach the mode logic
                    if (shreg[6:0] == dev_addr_in)
                    begin
                        addr_hit_out <= 1'b1;
                        activity_out <= 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/gpmc_top.sv */
// Purpose: Power-mode sequencing and low-capacity flag of a battery gauge
// Assumes: Measurements and settings arrive as words on the core clock
// Notes:   Host commands are detected by address match on the link pins
// Notes on behaviour
// - Host commands over I2C are serviced in every mode.
// - Low-capacity flag sets when remaining capacity drops below set level.
// - Flag clears only above separate clear level, giving hysteresis.
// - At end-of-discharge voltage the reported charge is forced to zero.
// - No cell: halt and wait; on insertion measure OPEN_CIRCUIT_VOLTAGE, flag, pick profile.
// - Halted wait mode wakes for host commands, then halts again.
// - Normal mode whenever no other mode is active.
// - Normal mode measures, refreshes data and decides mode changes.
// - Doze entered when doze allowed and average current below doze level.
// - Coulomb counter autocalibration runs before doze entry.
// - Doze stops the high-frequency oscillator.
// - Doze wakes periodically to measure and update data.
// - Doze exits on average current above level or current above wake.
// - Fast doze entered when its bit is set and current below doze level.
// - Fast doze keeps both oscillators running.
// - Fast doze exits on communication, current rise or wake current.
// - Requested deep-off waits for valid OPEN_CIRCUIT_VOLTAGE and small average current.
// - Deep-off also entered on low cell voltage with valid OPEN_CIRCUIT_VOLTAGE.
// - Deep-off left only on addressed I2C command or power-on reset.
// - Cell removed on charger: stop tracking, go to insertion check.
`timescale 1ns/1ns
`default_nettype none
module gpmc_top
(
    input  wire logic                            ref_clk_in,
    input  wire logic                            rst_b_in,
    input  wire logic                            scl_in,
    input  wire logic                            sda_in,
    input  wire logic [gpmc_pkg::I2C_ADDR_W-1:0] dev_addr_in,
    input  wire logic                            cell_present_in,
    input  wire logic                            doze_allow_in,
    input  wire logic                            fast_doze_enable_bit_in,
    input  wire logic                            deep_off_request_in,
    input  wire gpmc_pkg::gpmc_cfg_t             cfg_in,
    input  wire gpmc_pkg::gpmc_meas_t            meas_in,
    input  wire logic                            cal_done_in,
    input  wire logic                            ocv_done_in,
    output logic                                 low_capacity_flag_out,
    output logic                                 battery_present_flag_out,
    output logic [gpmc_pkg::DATA_W-1:0]          state_of_charge_out,
    output logic                                 hf_osc_en_out,
    output logic                                 lf_osc_en_out,
    output logic                                 measure_req_out,
    output logic                                 cal_req_out,
    output logic                                 ocv_req_out,
    output logic                                 profile_select_out,
    output logic                                 tracking_en_out,
    output logic                                 cmd_service_out,
    output logic [3:0]                           mode_out
);
    gpmc_pkg::gpmc_state_t state;
    gpmc_pkg::gpmc_state_t next_state;
    logic                          addr_hit;
    logic                          activity;
    logic [2:0]                    cell_s;
    logic                          cell_q;
    logic                          ocv_valid;
    logic [gpmc_pkg::CNT_W-1:0]    doze_cnt;
    logic                          doze_tick;
    logic                          doze_qual;
    logic                          wake_cur;
    logic                          deep_qual;

    function automatic logic [gpmc_pkg::DATA_W-1:0] mag
        (input logic [gpmc_pkg::DATA_W-1:0] v);
        mag = v[gpmc_pkg::DATA_W-1] ? (~v + 16'h0001) : v;
    endfunction

    gpmc_i2c_addr_det u_det
    (
        .ref_clk_in   (ref_clk_in),
        .rst_b_in     (rst_b_in),
        .scl_in       (scl_in),
        .sda_in       (sda_in),
        .dev_addr_in  (dev_addr_in),
        .addr_hit_out (addr_hit),
        .activity_out (activity)
    );

    // Cell detect comes from a pin, so it is filtered like the link pins
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            cell_s <= 3'h0;
            cell_q <= 1'b0;
        end
        else
        begin
            cell_s <= {cell_s[1:0], cell_present_in};
            if (cell_s[1] == cell_s[2])
                cell_q <= cell_s[2];
        end
    end

    assign doze_qual = mag(meas_in.average_current_value)
                       < cfg_in.doze_current_level;
    assign wake_cur  = mag(meas_in.sense_current)
                       > cfg_in.wake_current_threshold;
    assign deep_qual = ocv_valid &&
        ((deep_off_request_in &&
          mag(meas_in.average_current_value)
          < cfg_in.deep_off_current_level) ||
         (meas_in.cell_voltage < cfg_in.deep_off_voltage_level));

    always_comb
    begin
        next_state = state;
        case (state)
            gpmc_pkg::GPMC_WAIT_ABSENT:
                if (cell_q)
                    next_state = gpmc_pkg::GPMC_INIT_OCV;
                else if (addr_hit)
                    next_state = gpmc_pkg::GPMC_CMD_WAKE;
            gpmc_pkg::GPMC_CMD_WAKE:
                next_state = cell_q ? gpmc_pkg::GPMC_INIT_OCV
                                    : gpmc_pkg::GPMC_WAIT_ABSENT;
            gpmc_pkg::GPMC_INIT_OCV:
                if (!cell_q)
                    next_state = gpmc_pkg::GPMC_WAIT_ABSENT;
                else if (ocv_done_in)
                    next_state = gpmc_pkg::GPMC_NORMAL;
            // Deep-off outranks doze; removal outranks both
            gpmc_pkg::GPMC_NORMAL:
                if (!cell_q)
                    next_state = gpmc_pkg::GPMC_WAIT_ABSENT;
                else if (deep_qual)
                    next_state = gpmc_pkg::GPMC_DEEP_OFF;
                else if (doze_qual && !wake_cur &&
                         (doze_allow_in || fast_doze_enable_bit_in))
                    next_state = gpmc_pkg::GPMC_CAL;
            gpmc_pkg::GPMC_CAL:
                if (!cell_q)
                    next_state = gpmc_pkg::GPMC_WAIT_ABSENT;
                else if (!doze_qual || wake_cur)
                    next_state = gpmc_pkg::GPMC_NORMAL;
                else if (cal_done_in)
                    next_state = fast_doze_enable_bit_in
                                 ? gpmc_pkg::GPMC_FAST_DOZE
                                 : gpmc_pkg::GPMC_DOZE;
            gpmc_pkg::GPMC_DOZE:
                if (!cell_q)
                    next_state = gpmc_pkg::GPMC_WAIT_ABSENT;
                else if (!doze_qual || wake_cur || !doze_allow_in)
                    next_state = gpmc_pkg::GPMC_NORMAL;
            gpmc_pkg::GPMC_FAST_DOZE:
                if (!cell_q)
                    next_state = gpmc_pkg::GPMC_WAIT_ABSENT;
                else if (activity || !doze_qual || wake_cur ||
                         !fast_doze_enable_bit_in)
                    next_state = gpmc_pkg::GPMC_NORMAL;
            gpmc_pkg::GPMC_DEEP_OFF:
                if (addr_hit)
                    next_state = gpmc_pkg::GPMC_INIT_OCV;
            default:
                next_state = gpmc_pkg::GPMC_WAIT_ABSENT;
        endcase
    end

    // Reset lands in wait mode; a present cell moves on next cycles
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            state <= gpmc_pkg::GPMC_WAIT_ABSENT;
        else
            state <= next_state;
    end

    // Periodic wake divider for doze; parked at zero outside doze modes
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in || !(state == gpmc_pkg::GPMC_DOZE ||
                           state == gpmc_pkg::GPMC_FAST_DOZE))
        begin
            doze_cnt  <= '0;
            doze_tick <= 1'b0;
        end
        else
        begin
            doze_tick <= (doze_cnt == gpmc_pkg::DOZE_PERIOD_DEF);
            doze_cnt  <= (doze_cnt == gpmc_pkg::DOZE_PERIOD_DEF)
                         ? '0 : doze_cnt + 24'h000001;
        end
    end

    // OPEN_CIRCUIT_VOLTAGE validity lost on removal or after deep-off, forcing a new one
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            ocv_valid                <= 1'b0;
            battery_present_flag_out <= 1'b0;
        end
        else if (state == gpmc_pkg::GPMC_WAIT_ABSENT ||
                 state == gpmc_pkg::GPMC_DEEP_OFF)
        begin
            ocv_valid <= 1'b0;
            if (state == gpmc_pkg::GPMC_WAIT_ABSENT)
                battery_present_flag_out <= 1'b0;
        end
        else if (state == gpmc_pkg::GPMC_INIT_OCV && ocv_done_in)
        begin
            ocv_valid                <= 1'b1;
            battery_present_flag_out <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            low_capacity_flag_out <= 1'b0;
        else if (meas_in.remaining_capacity_value
                 < cfg_in.low_capacity_set_level)
            low_capacity_flag_out <= 1'b1;
        else if (meas_in.remaining_capacity_value
                 > cfg_in.low_capacity_clear_level)
            low_capacity_flag_out <= 1'b0;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
            state_of_charge_out <= gpmc_pkg::ZERO_WORD;
        else if (meas_in.cell_voltage <= cfg_in.end_discharge_voltage)
            state_of_charge_out <= gpmc_pkg::ZERO_WORD;
        else
            state_of_charge_out <= meas_in.state_of_charge;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            hf_osc_en_out      <= 1'b1;
            lf_osc_en_out      <= 1'b1;
            measure_req_out    <= 1'b0;
            cal_req_out        <= 1'b0;
            ocv_req_out        <= 1'b0;
            profile_select_out <= 1'b0;
            tracking_en_out    <= 1'b0;
            cmd_service_out    <= 1'b0;
            mode_out           <= 4'h0;
        end
        else
        begin
            hf_osc_en_out   <= !(state == gpmc_pkg::GPMC_DOZE ||
                                 state == gpmc_pkg::GPMC_DEEP_OFF ||
                                 state == gpmc_pkg::GPMC_WAIT_ABSENT);
            lf_osc_en_out   <= state != gpmc_pkg::GPMC_DEEP_OFF;
            measure_req_out <= state == gpmc_pkg::GPMC_NORMAL ||
                               doze_tick;
            cal_req_out     <= state == gpmc_pkg::GPMC_CAL;
            ocv_req_out     <= state == gpmc_pkg::GPMC_INIT_OCV;
            profile_select_out <= state == gpmc_pkg::GPMC_INIT_OCV &&
                                  ocv_done_in;
            tracking_en_out <= !(state == gpmc_pkg::GPMC_WAIT_ABSENT ||
                                 state == gpmc_pkg::GPMC_CMD_WAKE ||
                                 state == gpmc_pkg::GPMC_DEEP_OFF);
            cmd_service_out <= addr_hit;
            mode_out        <= state;
        end
    end

    // All checks live on the core clock and sleep through reset
    default clocking core_cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    property p_lowcap_set;
        (meas_in.remaining_capacity_value < cfg_in.low_capacity_set_level)
        |=> low_capacity_flag_out;
    endproperty
    a_lowcap_set: assert property (p_lowcap_set)
        else $error("low capacity flag not set");
    property p_lowcap_hold;
        (low_capacity_flag_out && meas_in.remaining_capacity_value
         <= cfg_in.low_capacity_clear_level) |=> low_capacity_flag_out;
    endproperty
    a_lowcap_hold: assert property (p_lowcap_hold)
        else $error("low capacity flag cleared early");
    property p_soc_zero;
        (meas_in.cell_voltage <= cfg_in.end_discharge_voltage)
        |=> (state_of_charge_out == gpmc_pkg::ZERO_WORD);
    endproperty
    a_soc_zero: assert property (p_soc_zero)
        else $error("charge not forced to zero");
    sequence s_cal_done;
        state == gpmc_pkg::GPMC_CAL && cal_done_in && doze_qual && !wake_cur
        && cell_q;
    endsequence
    property p_doze_after_cal;
        s_cal_done |=> (state == gpmc_pkg::GPMC_DOZE ||
                        state == gpmc_pkg::GPMC_FAST_DOZE);
    endproperty
    a_doze_after_cal: assert property (p_doze_after_cal)
        else $error("doze not entered after calibration");
    property p_doze_via_cal;
        (state == gpmc_pkg::GPMC_DOZE && $changed(state))
        |-> ($past(state) == gpmc_pkg::GPMC_CAL);
    endproperty
    a_doze_via_cal: assert property (p_doze_via_cal)
        else $error("doze entered without calibration");
    property p_hf_off;
        (state == gpmc_pkg::GPMC_DOZE) |=> !hf_osc_en_out;
    endproperty
    a_hf_off: assert property (p_hf_off)
        else $error("fast oscillator running in doze");
    property p_fast_exit;
        (state == gpmc_pkg::GPMC_FAST_DOZE && activity && cell_q)
        |=> (state == gpmc_pkg::GPMC_NORMAL);
    endproperty
    a_fast_exit: assert property (p_fast_exit)
        else $error("fast doze not left on communication");
    property p_deep_stay;
        (state == gpmc_pkg::GPMC_DEEP_OFF && !addr_hit)
        |=> (state == gpmc_pkg::GPMC_DEEP_OFF);
    endproperty
    a_deep_stay: assert property (p_deep_stay)
        else $error("deep-off left without addressed command");
    property p_deep_needs_ocv;
        (state == gpmc_pkg::GPMC_DEEP_OFF && $changed(state))
        |-> $past(ocv_valid);
    endproperty
    a_deep_needs_ocv: assert property (p_deep_needs_ocv)
        else $error("deep-off without valid OPEN_CIRCUIT_VOLTAGE");
    property p_removal;
        (state == gpmc_pkg::GPMC_NORMAL && !cell_q)
        |=> (state == gpmc_pkg::GPMC_WAIT_ABSENT) ##1 !tracking_en_out;
    endproperty
    a_removal: assert property (p_removal)
        else $error("removal not handled");
endmodule
`default_nettype wire

/* File: bench/gpmc_host_model.sv */
// Purpose: Host end of the link, sends one addressed write frame
// Assumes: Open-drain lines with pull-ups, so a released line reads 1
// Notes:   Link clock stands high between frames, 160 ns period inside
`timescale 1ns/1ns
`default_nettype none
module gpmc_host_model
(
    input  wire logic       ref_clk_in,
    input  wire logic       start_in,
    input  wire logic [6:0] addr_in,
    output logic            busy_out,
    output logic            scl_out,
    output logic            sda_out
);
    logic [7:0] frame;
    initial
    begin
        busy_out = 1'b0;
        scl_out  = 1'b1;
        sda_out  = 1'b1;
    end
    // Ninth clock leaves data released; the gauge only listens
    always @(posedge ref_clk_in)
    begin
        if (start_in && !busy_out)
        begin
            busy_out = 1'b1;
            frame    = {addr_in, 1'b0};
            // Pins move 1 ns after the edge so the gauge never races them
            #1 sda_out = 1'b0;
            #80;
            for (int i = 8; i >= 0; i--)
            begin
                scl_out = 1'b0;
                #40 sda_out = (i == 0) ? 1'b1 : frame[i-1];
                #40 scl_out = 1'b1;
                #80;
            end
            scl_out = 1'b0;
            #40 sda_out = 1'b0;
            #40 scl_out = 1'b1;
            #40 sda_out = 1'b1;
            #79 busy_out = 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: Self-checking bench for the gauge power-mode controller
// Assumes: Done handshakes are driven by the bench, not auto-answered
// Notes:   Doze tick period is not shortenable, so ticks go unchecked
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) \
    begin checks++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    logic ref_clk_in = 1'b0, rst_b_in = 1'b0, cell_in = 1'b0;
    logic allow_in = 1'b0, fast_in = 1'b0, deep_in = 1'b0, start = 1'b0;
    logic cal_done = 1'b0, ocv_done = 1'b0;
    logic [6:0] addr = 7'h2a;
    wire logic scl_in, sda_in, busy;
    gpmc_pkg::gpmc_cfg_t  cfg = '{16'h0100, 16'h0200, 16'h0c00, 16'h0064,
                                  16'h1000, 16'h0064, 16'h0010};
    gpmc_pkg::gpmc_meas_t meas = '{16'h0300, 16'h0005, 16'h0000,
                                   16'h0e00, 16'h0032};
    logic low_flag, bat_flag, hf, lf, meas_req, cal_req, ocv_req;
    logic tracking, cmd_srv, prof;
    logic [15:0] soc;
    logic [3:0]  mode;
    logic [15:0] seen = '0;
    int          err_total = 0, checks = 0, hits = 0, profs = 0;
    logic [15:0] rc_v [6] = '{16'h0300, 16'h0100, 16'h00ff, 16'h0200,
                              16'h0201, 16'h00ff};
    logic        rc_f [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    gpmc_host_model i_gpmc_host_model (.ref_clk_in(ref_clk_in),
        .start_in(start), .addr_in(addr), .busy_out(busy),
        .scl_out(scl_in), .sda_out(sda_in));
    gpmc_top i_gpmc_top (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .scl_in(scl_in), .sda_in(sda_in), .dev_addr_in(7'h2a),
        .cell_present_in(cell_in), .doze_allow_in(allow_in),
        .fast_doze_enable_bit_in(fast_in), .deep_off_request_in(deep_in),
        .cfg_in(cfg), .meas_in(meas), .cal_done_in(cal_done),
        .ocv_done_in(ocv_done), .low_capacity_flag_out(low_flag),
        .battery_present_flag_out(bat_flag), .state_of_charge_out(soc),
        .hf_osc_en_out(hf), .lf_osc_en_out(lf), .measure_req_out(meas_req),
        .cal_req_out(cal_req), .ocv_req_out(ocv_req),
        .profile_select_out(prof), .tracking_en_out(tracking),
        .cmd_service_out(cmd_srv), .mode_out(mode));
    always #4 ref_clk_in = ~ref_clk_in;
    // Transient modes last a cycle, so every visited mode is recorded
    always @(posedge ref_clk_in)
    begin
        seen[mode] <= 1'b1;
        if (cmd_srv === 1'b1)
            hits <= hits + 1;
        if (prof === 1'b1)
            profs <= profs + 1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic wait_mode(input logic [3:0] m);
        for (int i = 0; i < 3000 && mode !== m; i++)
            step(1);
        `CHK(mode, m)
    endtask
    task automatic i2c(input logic [6:0] a);
        addr  = a;
        start = 1'b1;
        step(1);
        start = 1'b0;
        for (int i = 0; i < 1000 && busy; i++)
            step(1);
        step(10);
    endtask
    task automatic ocv_run();
        wait_mode(4'h1);
        `CHK(ocv_req, 1'b1)
        ocv_done = 1'b1;
        wait_mode(4'h2);
        ocv_done = 1'b0;
    endtask
    task automatic cal_run(input logic [3:0] m);
        wait_mode(4'h3);
        `CHK(cal_req, 1'b1)
        step(5);
        `CHK(mode, 4'h3)
        cal_done = 1'b1;
        wait_mode(m);
        cal_done = 1'b0;
    endtask
    task automatic final_report();
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        step(12);
        rst_b_in = 1'b1;
        step(10);
        `CHK(mode, 4'h0)
        `CHK(bat_flag, 1'b0)
        i2c(7'h2a);
        `CHK(seen[7], 1'b1)
        `CHK(mode, 4'h0)
        `CHK(hits, 1)
        cell_in = 1'b1;
        ocv_run();
        `CHK(bat_flag, 1'b1)
        `CHK(profs, 1)
        `CHK(meas_req, 1'b1)
        for (int k = 0; k < 6; k++)
        begin
            meas.remaining_capacity_value = rc_v[k];
            step(3);
            `CHK(low_flag, rc_f[k])
        end
        meas.cell_voltage = 16'h0c00;
        step(3);
        `CHK(soc, 16'h0000)
        meas.cell_voltage = 16'h0e00;
        step(3);
        `CHK(soc, 16'h0032)
        allow_in = 1'b1;
        cal_run(4'h4);
        `CHK(hf, 1'b0)
        meas.average_current_value = 16'h0200;
        wait_mode(4'h2);
        meas.average_current_value = 16'h0005;
        fast_in = 1'b1;
        cal_run(4'h5);
        `CHK({hf, lf}, 2'b11)
        seen = '0;
        i2c(7'h2a);
        `CHK(seen[2], 1'b1)
        meas.average_current_value = 16'h0200;
        allow_in = 1'b0;
        fast_in  = 1'b0;
        step(5);
        cal_done = 1'b1;
        wait_mode(4'h2);
        cal_done = 1'b0;
        meas.average_current_value = 16'h0005;
        deep_in = 1'b1;
        wait_mode(4'h6);
        deep_in = 1'b0;
        i2c(7'h15);
        `CHK(mode, 4'h6)
        `CHK(hits, 2)
        i2c(7'h2a);
        ocv_run();
        meas.cell_voltage = 16'h000f;
        wait_mode(4'h6);
        meas.cell_voltage = 16'h0e00;
        i2c(7'h2a);
        ocv_run();
        cell_in = 1'b0;
        wait_mode(4'h0);
        `CHK(tracking, 1'b0)
        `CHK(hits, 4)
        `CHK(profs, 3)
        final_report();
    end
    // Whole run needs a little over twelve hundred cycles; allow ample margin
    initial
    begin
        #(20000 * 8);
        err_total++;
        final_report();
    end
endmodule
`default_nettype wire
